// file: crlc_pkg.sv
// crlc_pkg: shared constants and carrier types for the cache RAM latency and counter control block.
// assumes a 32-bit classic wishbone register bus and one 100 MHz clock.
package crlc_pkg;
	// ==========================================================
	// register map (word aligned byte addresses)
	localparam logic [7:0] TAG_LAT_ADDR = 8'h00;
	localparam logic [7:0] DATA_LAT_ADDR = 8'h04;
	localparam logic [7:0] EV_CTRL_ADDR = 8'h08;
	localparam logic [7:0] CACHE_CTRL_ADDR = 8'h0C;
	localparam logic [7:0] EV_CNT0_ADDR = 8'h10;
	localparam logic [7:0] EV_CNT1_ADDR = 8'h14;
	localparam logic [7:0] SEQ_CTRL_ADDR = 8'h18;
	localparam logic [7:0] SEQ_STAT_ADDR = 8'h1C;

	// ==========================================================
	// field positions
	localparam int SETUP_LSB = 0;
	localparam int RD_LSB = 4;
	localparam int WR_LSB = 8;
	localparam int LAT_W = 3;
	localparam int EV_EN_BIT = 0;
	localparam int EV_RST0_BIT = 1;
	localparam int EV_RST1_BIT = 2;
	localparam int CACHE_EN_BIT = 0;
	localparam int SEQ_GO_BIT = 0;
	localparam int SEQ_WR_BIT = 1;
	localparam int SEQ_DATA_BIT = 2;
	localparam int SEQ_BUSY_BIT = 0;

	// ==========================================================
	// bus error codes returned in err_code_o
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ==========================================================
	// carrier for one latency field set
	typedef struct packed {
		logic [2:0] wr;
		logic [2:0] rd;
		logic [2:0] setup;
	} crlc_lat_t;

	// pack a latency set into its register image, unused bits zero
	function automatic logic [31:0] lat_image(input crlc_lat_t l);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[WR_LSB +: LAT_W] = l.wr;
		v[RD_LSB +: LAT_W] = l.rd;
		v[SETUP_LSB +: LAT_W] = l.setup;
		return v;
	endfunction : lat_image
endpackage : crlc_pkg

// file: crlc_evcnt.sv
// crlc_evcnt: one saturating 32-bit event counter with a synchronous clear.
// assumes the event and clear are synchronous to clk_i.
`timescale 1ns/1ns
module crlc_evcnt (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic enable_i,
	input wire logic clear_i,
	input wire logic event_i,
	// value
	output logic [31:0] count_o
);
	// ==========================================================
	// counter: clear wins, saturates at all ones
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			count_o <= 32'h0000_0000;
		end else if (enable_i && event_i && count_o != 32'hFFFF_FFFF) begin
			count_o <= count_o + 32'h0000_0001;
		end
	end
endmodule : crlc_evcnt

// file: crlc_seq.sv
// crlc_seq: ram access sequencer that stretches setup then read or write phases.
// assumes latency fields are stable while a sequence runs.
`timescale 1ns/1ns
module crlc_seq (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// request
	input wire logic start_i,
	input wire logic write_i,
	input wire crlc_pkg::crlc_lat_t lat_i,
	// ram strobes and status
	output logic ram_ce_o,
	output logic ram_we_o,
	output logic busy_o,
	output logic done_o
);
	typedef enum logic [1:0] {S_IDLE, S_SETUP, S_ACCESS} crlc_seq_t;
	crlc_seq_t state_q;
	logic [2:0] cnt_q;

	// ==========================================================
	// phase machine: each phase lasts field+1 cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
			cnt_q <= 3'h0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (start_i) begin
						state_q <= S_SETUP;
						cnt_q <= lat_i.setup;
					end
				end
				S_SETUP: begin
					if (cnt_q == 3'h0) begin
						state_q <= S_ACCESS;
						cnt_q <= write_i ? lat_i.wr : lat_i.rd;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				S_ACCESS: begin
					if (cnt_q == 3'h0) begin
						state_q <= S_IDLE;
						done_o <= 1'b1;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ram strobes held stable across each phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ram_ce_o <= 1'b0;
			ram_we_o <= 1'b0;
			busy_o <= 1'b0;
		end else if (state_q == S_IDLE && start_i) begin
			ram_ce_o <= 1'b1;
			ram_we_o <= write_i;
			busy_o <= 1'b1;
		end else if (state_q == S_ACCESS && cnt_q == 3'h0) begin
			ram_ce_o <= 1'b0;
			ram_we_o <= 1'b0;
			busy_o <= 1'b0;
		end
	end
endmodule : crlc_seq

// file: crlc_regs.sv
// crlc_regs: latency and event counter control registers of a level-2 cache controller.
// assumes a classic wishbone master with a secure/non-secure attribute per access.
`timescale 1ns/1ns
module crlc_regs #(
	parameter logic [2:0] tag_wr_latency_param = 3'h0,
	parameter logic [2:0] tag_rd_latency_param = 3'h0,
	parameter logic [2:0] tag_setup_latency_param = 3'h0,
	parameter logic [2:0] data_wr_latency_param = 3'h0,
	parameter logic [2:0] data_rd_latency_param = 3'h0,
	parameter logic [2:0] data_setup_latency_param = 3'h0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic nonsecure_access_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	output logic [1:0] err_code_o,
	// event inputs
	input wire logic event0_i,
	input wire logic event1_i,
	// ram strobes
	output logic tag_ce_o,
	output logic tag_we_o,
	output logic data_ce_o,
	output logic data_we_o,
	// configuration to cache datapath
	output logic cache_en_o,
	output logic count_en_o
);
	// ==========================================================
	// storage
	crlc_pkg::crlc_lat_t tag_lat_q;
	crlc_pkg::crlc_lat_t data_lat_q;
	logic ev_en_q;
	logic cache_en_q;
	logic clr0_q;
	logic clr1_q;
	logic seq_go_q;
	logic seq_wr_q;
	logic seq_data_q;
	logic [31:0] cnt0;
	logic [31:0] cnt1;
	logic tag_busy;
	logic data_busy;
	logic tag_ce;
	logic tag_we;
	logic data_ce;
	logic data_we;

	// ==========================================================
	// bus decode: one access per strobe, answered on the next edge
	logic req;
	logic wr;
	logic lat_hit;
	logic [1:0] resp;
	logic [31:0] rdata;
	assign req = cyc_i && stb_i && !ack_o && !err_o;
	assign wr = req && we_i;
	assign lat_hit = adr_i == crlc_pkg::TAG_LAT_ADDR || adr_i == crlc_pkg::DATA_LAT_ADDR;

	// byte-lane merge of a write into a 32-bit image
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				v[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return v;
	endfunction : merge

	// unpack the latency fields, dropping unused bits
	function automatic crlc_pkg::crlc_lat_t lat_unpack(input logic [31:0] v);
		crlc_pkg::crlc_lat_t l;
		l.wr = v[crlc_pkg::WR_LSB +: crlc_pkg::LAT_W];
		l.rd = v[crlc_pkg::RD_LSB +: crlc_pkg::LAT_W];
		l.setup = v[crlc_pkg::SETUP_LSB +: crlc_pkg::LAT_W];
		return l;
	endfunction : lat_unpack

	// response code: decode error beats slave error for latency writes
	always_comb begin
		resp = crlc_pkg::RESP_OKAY;
		if (wr && lat_hit) begin
			if (nonsecure_access_i) begin
				resp = crlc_pkg::RESP_DECERR;
			end else if (cache_en_q) begin
				resp = crlc_pkg::RESP_SLVERR;
			end
		end
	end

	// read mux, unused bits read zero
	always_comb begin
		rdata = 32'h0000_0000;
		case (adr_i)
			crlc_pkg::TAG_LAT_ADDR: rdata = crlc_pkg::lat_image(tag_lat_q);
			crlc_pkg::DATA_LAT_ADDR: rdata = crlc_pkg::lat_image(data_lat_q);
			crlc_pkg::EV_CTRL_ADDR: rdata[crlc_pkg::EV_EN_BIT] = ev_en_q;
			crlc_pkg::CACHE_CTRL_ADDR: rdata[crlc_pkg::CACHE_EN_BIT] = cache_en_q;
			crlc_pkg::EV_CNT0_ADDR: rdata = cnt0;
			crlc_pkg::EV_CNT1_ADDR: rdata = cnt1;
			crlc_pkg::SEQ_CTRL_ADDR: begin
				rdata[crlc_pkg::SEQ_WR_BIT] = seq_wr_q;
				rdata[crlc_pkg::SEQ_DATA_BIT] = seq_data_q;
			end
			crlc_pkg::SEQ_STAT_ADDR: rdata[crlc_pkg::SEQ_BUSY_BIT] = tag_busy || data_busy;
			default: rdata = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// bus answer: ack or err one cycle after the strobe, for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			err_code_o <= crlc_pkg::RESP_OKAY;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req && resp == crlc_pkg::RESP_OKAY;
			err_o <= req && resp != crlc_pkg::RESP_OKAY;
			err_code_o <= req ? resp : crlc_pkg::RESP_OKAY;
			dat_o <= (req && !we_i) ? rdata : 32'h0000_0000;
		end
	end

	// ==========================================================
	// latency registers, reset from build parameters
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tag_lat_q <= '{wr: tag_wr_latency_param, rd: tag_rd_latency_param,
				setup: tag_setup_latency_param};
			data_lat_q <= '{wr: data_wr_latency_param, rd: data_rd_latency_param,
				setup: data_setup_latency_param};
		end else if (wr && resp == crlc_pkg::RESP_OKAY) begin
			// latency writes reach here only if secure with the cache off
			if (adr_i == crlc_pkg::TAG_LAT_ADDR) begin
				tag_lat_q <= lat_unpack(merge(crlc_pkg::lat_image(tag_lat_q), dat_i, sel_i));
			end
			if (adr_i == crlc_pkg::DATA_LAT_ADDR) begin
				data_lat_q <= lat_unpack(merge(crlc_pkg::lat_image(data_lat_q), dat_i, sel_i));
			end
		end
	end

	// ==========================================================
	// event counter control: enable stored, reset bits pulse only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_en_q <= 1'b0;
			clr0_q <= 1'b0;
			clr1_q <= 1'b0;
		end else begin
			clr0_q <= 1'b0;
			clr1_q <= 1'b0;
			if (wr && adr_i == crlc_pkg::EV_CTRL_ADDR && sel_i[0]) begin
				ev_en_q <= dat_i[crlc_pkg::EV_EN_BIT];
				clr0_q <= dat_i[crlc_pkg::EV_RST0_BIT];
				clr1_q <= dat_i[crlc_pkg::EV_RST1_BIT];
			end
		end
	end

	// cache enable control bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cache_en_q <= 1'b0;
		end else if (wr && adr_i == crlc_pkg::CACHE_CTRL_ADDR && sel_i[0]) begin
			cache_en_q <= dat_i[crlc_pkg::CACHE_EN_BIT];
		end
	end

	// sequencer trigger: go pulses one cycle, direction and target stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_go_q <= 1'b0;
			seq_wr_q <= 1'b0;
			seq_data_q <= 1'b0;
		end else begin
			seq_go_q <= 1'b0;
			if (wr && adr_i == crlc_pkg::SEQ_CTRL_ADDR && sel_i[0]) begin
				seq_go_q <= dat_i[crlc_pkg::SEQ_GO_BIT];
				seq_wr_q <= dat_i[crlc_pkg::SEQ_WR_BIT];
				seq_data_q <= dat_i[crlc_pkg::SEQ_DATA_BIT];
			end
		end
	end

	// ==========================================================
	// event counters
	crlc_evcnt u_cnt0 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(ev_en_q),
		.clear_i(clr0_q),
		.event_i(event0_i),
		.count_o(cnt0)
	);
	crlc_evcnt u_cnt1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(ev_en_q),
		.clear_i(clr1_q),
		.event_i(event1_i),
		.count_o(cnt1)
	);

	// ==========================================================
	// ram sequencers, one per ram, each with its own latency set
	crlc_seq u_tag_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(seq_go_q && !seq_data_q && !tag_busy),
		.write_i(seq_wr_q),
		.lat_i(tag_lat_q),
		.ram_ce_o(tag_ce),
		.ram_we_o(tag_we),
		.busy_o(tag_busy),
		.done_o()
	);
	crlc_seq u_data_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(seq_go_q && seq_data_q && !data_busy),
		.write_i(seq_wr_q),
		.lat_i(data_lat_q),
		.ram_ce_o(data_ce),
		.ram_we_o(data_we),
		.busy_o(data_busy),
		.done_o()
	);

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tag_ce_o <= 1'b0;
			tag_we_o <= 1'b0;
			data_ce_o <= 1'b0;
			data_we_o <= 1'b0;
			cache_en_o <= 1'b0;
			count_en_o <= 1'b0;
		end else begin
			tag_ce_o <= tag_ce;
			tag_we_o <= tag_we;
			data_ce_o <= data_ce;
			data_we_o <= data_we;
			cache_en_o <= cache_en_q;
			count_en_o <= ev_en_q;
		end
	end

	// ==========================================================
	// checks
	a_ns_write_decerr: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && lat_hit && nonsecure_access_i |=> err_o && err_code_o == crlc_pkg::RESP_DECERR)
		else $error("non-secure latency write not refused with decode error");
	a_ns_write_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && lat_hit && nonsecure_access_i |=> $stable(tag_lat_q) && $stable(data_lat_q))
		else $error("non-secure latency write changed a register");
	a_enabled_slverr: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && lat_hit && !nonsecure_access_i && cache_en_q |=> err_o && err_code_o == crlc_pkg::RESP_SLVERR)
		else $error("latency write with cache on not refused");
	a_lat_read_ok: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && adr_i == crlc_pkg::TAG_LAT_ADDR |=> ack_o && !err_o
		&& dat_o == crlc_pkg::lat_image($past(tag_lat_q)))
		else $error("tag latency read wrong or errored");
	a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && lat_hit |=> dat_o[31:11] == 21'h0 && !dat_o[7] && !dat_o[3])
		else $error("unused latency bits not zero");
	a_rst_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && adr_i == crlc_pkg::EV_CTRL_ADDR |=> dat_o[2:1] == 2'h0)
		else $error("counter reset bits read non-zero");
	a_cnt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == crlc_pkg::EV_CTRL_ADDR && sel_i[0] && dat_i[crlc_pkg::EV_RST1_BIT] |=> ##1 cnt1 == 32'h0)
		else $error("counter 1 not cleared");
	a_cnt_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		!ev_en_q && !clr0_q |=> $stable(cnt0))
		else $error("counter 0 moved while counting disabled");
	a_evctrl_no_err: assert property (@(posedge clk_i) disable iff (rst_i)
		req && adr_i == crlc_pkg::EV_CTRL_ADDR |=> ack_o && !err_o)
		else $error("counter control access errored");
	a_seq_stretch: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(tag_busy) && tag_lat_q == '0 |=> ##1 !tag_busy)
		else $error("tag sequence length wrong for zero latency");
	a_cnt0_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == crlc_pkg::EV_CTRL_ADDR && sel_i[0] && dat_i[crlc_pkg::EV_RST0_BIT] |=> ##1 cnt0 == 32'h0)
		else $error("counter 0 not cleared");
	a_cnt1_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		!ev_en_q && !clr1_q |=> $stable(cnt1))
		else $error("counter 1 moved while counting disabled");
	a_en_reset_zero: assert property (@(posedge clk_i)
		$past(rst_i) |-> !ev_en_q && !count_en_o && !cache_en_q)
		else $error("enables not zero after reset");
	a_tag_rst_value: assert property (@(posedge clk_i)
		$past(rst_i) |-> tag_lat_q == {tag_wr_latency_param, tag_rd_latency_param, tag_setup_latency_param})
		else $error("tag latency reset value wrong");
	a_data_rst_value: assert property (@(posedge clk_i)
		$past(rst_i) |-> data_lat_q == {data_wr_latency_param, data_rd_latency_param, data_setup_latency_param})
		else $error("data latency reset value wrong");
	a_data_read_ok: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && adr_i == crlc_pkg::DATA_LAT_ADDR |=> ack_o && !err_o
		&& dat_o == crlc_pkg::lat_image($past(data_lat_q)))
		else $error("data latency read wrong or errored");
	a_tag_fields: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == crlc_pkg::TAG_LAT_ADDR && !nonsecure_access_i && !cache_en_q && sel_i == 4'hF
		|=> tag_lat_q.wr == $past(dat_i[crlc_pkg::WR_LSB +: crlc_pkg::LAT_W])
		&& tag_lat_q.rd == $past(dat_i[crlc_pkg::RD_LSB +: crlc_pkg::LAT_W])
		&& tag_lat_q.setup == $past(dat_i[crlc_pkg::SETUP_LSB +: crlc_pkg::LAT_W]))
		else $error("tag latency fields not stored in place");
	a_slverr_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && lat_hit && cache_en_q |=> $stable(tag_lat_q) && $stable(data_lat_q))
		else $error("latency write with cache on changed a register");
	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_err_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		err_o |=> !err_o)
		else $error("err held longer than one cycle");
	a_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		!ack_o |-> dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
endmodule : crlc_regs

// file: crlc_master.sv
// crlc_master: classic wishbone master model issuing secure or non-secure accesses.
// assumes the slave answers each request with a one-cycle ack or err and a response code.
`timescale 1ns/1ns
module crlc_master (
	// clock
	input wire logic clk_i,
	// wishbone master side
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	output logic nonsecure_access_o,
	// slave answer
	input wire logic [31:0] dat_i,
	input wire logic ack_i,
	input wire logic err_i,
	input wire logic [1:0] err_code_i
);
	// ==========================================================
	// idle bus at time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'hA5;
		sel_o = 4'h0;
		dat_o = 32'h5A5A_5A5A;
		nonsecure_access_o = 1'b1;
	end

	// ==========================================================
	// one single cycle; request held until ack or err is sampled high
	task automatic access(input logic wr, input logic [7:0] adr, input logic [31:0] wdat, input logic ns,
		input logic [3:0] sel, output logic [31:0] rdat, output logic [2:0] resp);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= wr;
		adr_o <= adr;
		sel_o <= sel;
		dat_o <= wdat;
		nonsecure_access_o <= ns;
		@(posedge clk_i);
		while (ack_i !== 1'b1 && err_i !== 1'b1) @(posedge clk_i);
		rdat = dat_i;
		resp = {err_i, err_code_i};
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// released lines show no stale request
		adr_o <= ~adr;
		dat_o <= ~wdat;
	endtask : access
endmodule : crlc_master

// file: crlc_regs_tb.sv
// crlc_regs_tb: self-checking bench for the latency and event counter control registers.
// assumes the master model crlc_master and the register map of crlc_pkg.
`timescale 1ns/1ns
module crlc_regs_tb;
	// ==========================================================
	// signals
	logic clk_i, rst_i, cyc, stb, we, ns, ack, err, ev0, ev1;
	logic tag_ce, tag_we, data_ce, data_we, cache_en, count_en;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdata, rdat;
	logic [1:0] code;
	logic [2:0] resp;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	int m;
	localparam logic [2:0] R_OK = 3'h0;
	localparam logic [2:0] R_DEC = {1'b1, crlc_pkg::RESP_DECERR};
	localparam logic [2:0] R_SLV = {1'b1, crlc_pkg::RESP_SLVERR};

	// ==========================================================
	// design and master
	crlc_regs #(.tag_wr_latency_param(3'h5), .tag_rd_latency_param(3'h3), .tag_setup_latency_param(3'h1),
		.data_wr_latency_param(3'h2), .data_rd_latency_param(3'h7), .data_setup_latency_param(3'h6)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .nonsecure_access_i(ns), .dat_o(rdata), .ack_o(ack), .err_o(err), .err_code_o(code),
		.event0_i(ev0), .event1_i(ev1), .tag_ce_o(tag_ce), .tag_we_o(tag_we), .data_ce_o(data_ce),
		.data_we_o(data_we), .cache_en_o(cache_en), .count_en_o(count_en));
	crlc_master i_master (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat), .nonsecure_access_o(ns), .dat_i(rdata), .ack_i(ack), .err_i(err), .err_code_i(code));

	// clock and run length limit
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			$display("BAD run length expected below %0d seen %0d", 5000, cycles);
			conclude();
		end
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s, input logic [2:0] exp);
		i_master.access(1'b1, a, d, s, 4'hF, rdat, resp);
		chk("write response", {29'h0, exp}, {29'h0, resp});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic s, input logic [31:0] exp);
		i_master.access(1'b0, a, 32'h0000_0000, s, 4'hF, rdat, resp);
		chk("read response", 32'h0000_0000, {29'h0, resp});
		chk("read data", exp, rdat);
	endtask : rd
	task automatic pulse_events(input int len);
		@(posedge clk_i);
		ev0 <= 1'b1;
		ev1 <= 1'b1;
		repeat (len) @(posedge clk_i);
		ev0 <= 1'b0;
		ev1 <= 1'b0;
	endtask : pulse_events
	task automatic ce_cycles(input logic data_side, output int cnt, output int wcnt);
		cnt = 0;
		wcnt = 0;
		repeat (40) begin
			@(posedge clk_i);
			if ((data_side ? data_ce : tag_ce) === 1'b1) cnt++;
			if ((data_side ? data_we : tag_we) === 1'b1) wcnt++;
		end
	endtask : ce_cycles

	// ==========================================================
	// scenarios
	task automatic t_reset;
		chk("count enable", 32'h0, {31'h0, count_en});
		chk("cache enable", 32'h0, {31'h0, cache_en});
		rd(crlc_pkg::TAG_LAT_ADDR, 1'b0, 32'h0000_0531);
		rd(crlc_pkg::DATA_LAT_ADDR, 1'b1, 32'h0000_0276);
		rd(crlc_pkg::EV_CTRL_ADDR, 1'b1, 32'h0000_0000);
		rd(8'h40, 1'b0, 32'h0000_0000);
	endtask : t_reset
	task automatic t_latency;
		wr(crlc_pkg::TAG_LAT_ADDR, 32'hFFFF_FFFF, 1'b0, R_OK);
		rd(crlc_pkg::TAG_LAT_ADDR, 1'b1, 32'h0000_0777);
		wr(crlc_pkg::DATA_LAT_ADDR, 32'h0000_0123, 1'b1, R_DEC);
		rd(crlc_pkg::DATA_LAT_ADDR, 1'b0, 32'h0000_0276);
		wr(crlc_pkg::TAG_LAT_ADDR, 32'h0000_0321, 1'b0, R_OK);
		rd(crlc_pkg::TAG_LAT_ADDR, 1'b0, 32'h0000_0321);
		// only byte lane 1 written: write field moves, low byte kept
		i_master.access(1'b1, crlc_pkg::DATA_LAT_ADDR, 32'h0000_05FF, 1'b0, 4'h2, rdat, resp);
		chk("lane write response", {29'h0, R_OK}, {29'h0, resp});
		rd(crlc_pkg::DATA_LAT_ADDR, 1'b1, 32'h0000_0576);
	endtask : t_latency
	task automatic t_cache_en;
		wr(crlc_pkg::CACHE_CTRL_ADDR, 32'h0000_0001, 1'b0, R_OK);
		@(negedge clk_i);
		chk("cache enable", 32'h1, {31'h0, cache_en});
		wr(crlc_pkg::TAG_LAT_ADDR, 32'h0000_0000, 1'b0, R_SLV);
		wr(crlc_pkg::DATA_LAT_ADDR, 32'h0000_0000, 1'b1, R_DEC);
		rd(crlc_pkg::TAG_LAT_ADDR, 1'b0, 32'h0000_0321);
		wr(crlc_pkg::CACHE_CTRL_ADDR, 32'h0000_0000, 1'b0, R_OK);
	endtask : t_cache_en
	task automatic t_events;
		wr(crlc_pkg::EV_CTRL_ADDR, 32'h0000_0001, 1'b1, R_OK);
		@(negedge clk_i);
		chk("count enable", 32'h1, {31'h0, count_en});
		pulse_events(5);
		rd(crlc_pkg::EV_CNT0_ADDR, 1'b1, 32'h0000_0005);
		rd(crlc_pkg::EV_CNT1_ADDR, 1'b1, 32'h0000_0005);
		wr(crlc_pkg::EV_CTRL_ADDR, 32'h0000_0005, 1'b1, R_OK);
		rd(crlc_pkg::EV_CNT1_ADDR, 1'b0, 32'h0000_0000);
		rd(crlc_pkg::EV_CNT0_ADDR, 1'b0, 32'h0000_0005);
		rd(crlc_pkg::EV_CTRL_ADDR, 1'b1, 32'h0000_0001);
		wr(crlc_pkg::EV_CTRL_ADDR, 32'h0000_0002, 1'b0, R_OK);
		rd(crlc_pkg::EV_CNT0_ADDR, 1'b0, 32'h0000_0000);
		pulse_events(3);
		rd(crlc_pkg::EV_CNT1_ADDR, 1'b0, 32'h0000_0000);
		chk("count enable", 32'h0, {31'h0, count_en});
	endtask : t_events
	task automatic t_sequencer;
		wr(crlc_pkg::SEQ_CTRL_ADDR, 32'h0000_0001, 1'b0, R_OK);
		ce_cycles(1'b0, n, m);
		chk("tag read strobe cycles", 32'd5, 32'(n));
		chk("tag read write-strobe cycles", 32'd0, 32'(m));
		wr(crlc_pkg::SEQ_CTRL_ADDR, 32'h0000_0003, 1'b0, R_OK);
		ce_cycles(1'b0, n, m);
		chk("tag write strobe cycles", 32'd6, 32'(n));
		chk("tag write write-strobe cycles", 32'd6, 32'(m));
		wr(crlc_pkg::SEQ_CTRL_ADDR, 32'h0000_0005, 1'b0, R_OK);
		ce_cycles(1'b1, n, m);
		chk("data read strobe cycles", 32'd15, 32'(n));
		chk("data read write-strobe cycles", 32'd0, 32'(m));
		wr(crlc_pkg::SEQ_CTRL_ADDR, 32'h0000_0007, 1'b0, R_OK);
		ce_cycles(1'b1, n, m);
		chk("data write strobe cycles", 32'd13, 32'(n));
		chk("data write write-strobe cycles", 32'd13, 32'(m));
		// zero latency: one setup cycle and one access cycle
		wr(crlc_pkg::TAG_LAT_ADDR, 32'h0000_0000, 1'b0, R_OK);
		wr(crlc_pkg::SEQ_CTRL_ADDR, 32'h0000_0001, 1'b0, R_OK);
		ce_cycles(1'b0, n, m);
		chk("tag zero latency strobe cycles", 32'd2, 32'(n));
	endtask : t_sequencer

	// ==========================================================
	// verdict and end of run
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// main sequence: reset for 8 cycles, then every scenario
	initial begin
		rst_i = 1'b1;
		ev0 = 1'b0;
		ev1 = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_latency();
		t_cache_en();
		t_events();
		t_sequencer();
		conclude();
	end
endmodule : crlc_regs_tb
